// ### hw/serial_card_pkg.sv
package serial_card_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_MHZ = 100;
	localparam int SYNC_HALF_NS = 80;
	localparam int SYNC_HALF_CYC = (SYNC_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int CARD_CLK_HALF_NS = 50;
	localparam int CARD_HALF_CYC = (CARD_CLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int CARD_CLKS_PER_ETU = 372;
	localparam int ETU_NS = CARD_CLKS_PER_ETU * 2 * CARD_CLK_HALF_NS;
	localparam int ETU_HALF_CYC = ETU_NS * SYS_CLK_MHZ / 2000;
	localparam int DIV_W = 12;
	// ----------------------------------------
	// Frame positions, in bits and half etu
	// ----------------------------------------
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [4:0] HC_LAST_SMP = 5'h12;
	localparam logic [4:0] HC_ERR_START = 5'h15;
	localparam logic [4:0] HC_ERR_END = 5'h17;
	localparam logic [4:0] HC_END_OK = 5'h18;
	localparam logic [4:0] HC_END_RETRY = 5'h1C;
	localparam logic [7:0] START_DIRECT = 8'h3B;
	localparam logic [7:0] START_INVERSE = 8'h3F;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic txEn, rxEn, rxIrqEn, txIrqEn, cardMode, intClock, msbFirst, dataInvert, parityOdd;
	} ctrl_t;
	typedef struct packed {
		logic errSig, overrun, framing, parity, rxFull, txEnd, txEmpty;
	} stat_t;
	localparam stat_t STAT_RST = 7'h01;
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SYNC = 3'b010, ST_CARD = 3'b100} state_t;
	// Bit order and level mapping; a reversal undoes itself, so it serves both directions
	function automatic logic [7:0] to_line(input logic [7:0] b, input logic msb, input logic inv);
		logic [7:0] r;
		r = b;
		if (msb) begin
			for (int i = 0; i < 8; i++) r[i] = b[7 - i];
		end
		return inv ? ~r : r;
	endfunction : to_line
endpackage : serial_card_pkg

// ### hw/serial_sync_card.sv
// Contract
// - Receiver syncs to serial clock, shifts bits
// - Overrun: flag set, data and full kept
// - Good character: load data, set full
// - No reception while overrun, framing or parity flag set
// - Overrun halts transmit and receive
// - Controller write/read clears empty/full flag
// - Card mode: receive pin is shared line
// - Both enables, card mode: own frame read back
// - Card mode: clock pin drives card clock
// - Card frame: eight data plus parity
// - Two etu guard after parity
// - Parity error: low 1 etu at 10.5
// - Card error signal: retransmit after 2 etu
// - Direct convention decodes start as 3B
// - Inverse convention decodes start as 3F
// - Inversion on data only; parity by odd select
// - Sample received bits on rising clock
// - Internal clock: eight pulses, idle high
`timescale 1ns/10ps
`default_nettype none
module serial_sync_card
	import serial_card_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Control and host strobes
	input wire ctrl_t ctrl,
	input wire logic txWrite,
	input wire logic [7:0] txData,
	input wire logic dtcTxWrite,
	input wire logic dtcRxRead,
	input wire stat_t clearFlags,
	// Status and events
	output stat_t status,
	output logic [7:0] rxData,
	output logic rxFullIrq,
	output logic rxErrorIrq,
	output logic txEmptyIrq,
	// Pins
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic rxdIn,
	output logic rxdOut,
	output logic rxdOe,
	output logic txdOut
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] sckSync_r, rxdSync_r;
	logic sckPrev_r, rxdPrev_r;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sckSync_r <= 2'h3;
			rxdSync_r <= 2'h3;
			sckPrev_r <= 1'b1;
			rxdPrev_r <= 1'b1;
		end else begin
			sckSync_r <= {sckSync_r[0], sckIn};
			rxdSync_r <= {rxdSync_r[0], rxdIn};
			sckPrev_r <= sckSync_r[1];
			rxdPrev_r <= rxdSync_r[1];
		end
	end
	wire logic sckS = sckSync_r[1];
	wire logic rxdS = rxdSync_r[1];

	// ----------------------------------------
	// State and datapath registers
	// ----------------------------------------
	state_t state_r, state_nxt;
	stat_t stat_r, stat_nxt, setF, clrF;
	logic [DIV_W-1:0] divCnt_r, etuCnt_r;
	logic [4:0] halfCnt_r;
	logic [3:0] bitCnt_r;
	logic [9:0] txLine_r, rxLine_r;
	logic [7:0] txData_r, rxData_r;
	logic txAct_r, cardErr_r, sckOut_r, rxdOe_r, txdOut_r, sckOe_r;
	logic rxFullIrq_r, rxErrorIrq_r, txEmptyIrq_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire logic inIdle = state_r == ST_IDLE;
	wire logic inSync = state_r == ST_SYNC;
	wire logic inCard = state_r == ST_CARD;
	wire logic [DIV_W-1:0] divLimit = ctrl.cardMode ? DIV_W'(CARD_HALF_CYC - 1)
		: DIV_W'(SYNC_HALF_CYC - 1);
	wire logic divWrap = divCnt_r == divLimit;
	wire logic halfTick = etuCnt_r == DIV_W'(ETU_HALF_CYC - 1);
	wire logic errAny = stat_r.overrun | stat_r.framing | stat_r.parity;
	wire logic txReady = ctrl.txEn & !stat_r.txEmpty & !errAny;
	wire logic syncGo = inIdle & !ctrl.cardMode & !errAny
		& (ctrl.txEn ? !stat_r.txEmpty : ctrl.rxEn);
	wire logic cardTxGo = inIdle & ctrl.cardMode & txReady;
	wire logic cardRxGo = inIdle & ctrl.cardMode & ctrl.rxEn & !ctrl.txEn & !errAny
		& rxdPrev_r & !rxdS;
	wire logic loadTx = (syncGo & ctrl.txEn) | cardTxGo;
	// internal edges come from the divider, external from the pin
	wire logic intRise = ctrl.intClock & inSync & divWrap & !sckOut_r;
	wire logic intFall = ctrl.intClock & inSync & divWrap & sckOut_r;
	wire logic syncRise = inSync & (bitCnt_r < SYNC_BITS)
		& (ctrl.intClock ? intRise : (sckS & !sckPrev_r));
	wire logic syncFall = inSync & (bitCnt_r != 4'h0) & (bitCnt_r < SYNC_BITS)
		& (ctrl.intClock ? intFall : (!sckS & sckPrev_r));
	wire logic syncDone = inSync & (bitCnt_r == SYNC_BITS);
	wire logic [4:0] cardEnd = (txAct_r & cardErr_r) ? HC_END_RETRY : HC_END_OK;
	wire logic cardDone = inCard & (halfCnt_r == cardEnd);
	wire logic done = syncDone | cardDone;
	wire logic smpTick = inCard & halfTick & !halfCnt_r[0] & (halfCnt_r <= HC_LAST_SMP);
	// line parity covers the data bits as they stand on the line
	wire logic parErr = (^rxLine_r[9:1]) != ctrl.parityOdd;
	// convention decode of the received byte
	wire logic [7:0] rxByte = to_line(rxLine_r[8:1], ctrl.msbFirst, ctrl.dataInvert);
	wire logic [7:0] txByte = to_line(txData_r, ctrl.msbFirst, ctrl.dataInvert);
	// card error pulse seen during transmit forces a resend
	wire logic retry = cardDone & txAct_r & cardErr_r;
	// in card mode with both enables the own frame is read back as a received one
	wire logic rxDeliver = done & ctrl.rxEn & (inSync | (!parErr & !rxLine_r[0]));
	// drive start, data and parity, or the error pulse
	wire logic drvBit = txAct_r & (halfCnt_r <= HC_LAST_SMP + 5'h1)
		& !txLine_r[halfCnt_r[4:1]];
	wire logic drvErr = !txAct_r & parErr & (halfCnt_r >= HC_ERR_START) & (halfCnt_r < HC_ERR_END);
	wire logic lineLow = inCard & !cardDone & (drvBit | drvErr);

	// ----------------------------------------
	// Flags: a set always beats a clear
	// ----------------------------------------
	always_comb begin
		setF = '0;
		clrF = clearFlags;
		// overrun keeps full flag and data
		setF.overrun = rxDeliver & stat_r.rxFull;
		setF.rxFull = rxDeliver & !stat_r.rxFull;
		setF.parity = cardDone & ctrl.rxEn & parErr;
		setF.framing = cardDone & ctrl.rxEn & rxLine_r[0];
		setF.errSig = retry;
		setF.txEnd = done & txAct_r & !retry & stat_r.txEmpty;
		setF.txEmpty = loadTx | !ctrl.txEn;
		// controller accesses clear the flag on their own
		clrF.rxFull = clearFlags.rxFull | dtcRxRead;
		clrF.txEmpty = clearFlags.txEmpty | dtcTxWrite;
		clrF.txEnd = clearFlags.txEnd | loadTx;
		stat_nxt = setF | (stat_r & ~clrF);
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (syncGo) begin
					state_nxt = ST_SYNC;
				end else if (cardTxGo | cardRxGo) begin
					state_nxt = ST_CARD;
				end
			end
			ST_SYNC: begin
				if (syncDone | !(ctrl.txEn | ctrl.rxEn)) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_CARD: begin
				if (cardDone & !retry) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			stat_r <= STAT_RST;
			txData_r <= 8'h00;
			rxData_r <= 8'h00;
			txAct_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			stat_r <= stat_nxt;
			if (txWrite | dtcTxWrite) begin
				txData_r <= txData;
			end
			// data register only loads on a clean, non-overrun character
			if (setF.rxFull) begin
				rxData_r <= rxByte;
			end
			if (syncGo | cardTxGo | cardRxGo) begin
				txAct_r <= loadTx;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			txLine_r <= 10'h3FF;
			divCnt_r <= '0;
			sckOut_r <= 1'b1;
			sckOe_r <= 1'b0;
		end else begin
			sckOe_r <= ctrl.cardMode | ctrl.intClock;
			// frame is start, eight data bits, then parity
			if (loadTx) begin
				txLine_r <= {(^txByte) ^ ctrl.parityOdd, txByte, 1'b0};
			end
			divCnt_r <= (syncGo | divWrap) ? '0 : DIV_W'(divCnt_r + 1'b1);
			// card clock runs free; sync clock idles high
			if (ctrl.cardMode | (inSync & ctrl.intClock)) begin
				sckOut_r <= divWrap ? !sckOut_r : sckOut_r;
			end else begin
				sckOut_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bitCnt_r <= 4'h0;
			rxLine_r <= 10'h3FF;
			txdOut_r <= 1'b1;
		end else begin
			// shift received bits on rising edges
			if (syncGo) begin
				bitCnt_r <= 4'h0;
			end else if (syncRise) begin
				bitCnt_r <= bitCnt_r + BIT_STEP;
			end
			if (syncRise) begin
				rxLine_r[bitCnt_r + BIT_STEP] <= rxdS;
			end else if (smpTick) begin
				rxLine_r[halfCnt_r[4:1]] <= rxdS;
			end
			// in card mode the transmit pin idles, the shared line carries data
			if (ctrl.cardMode) begin
				txdOut_r <= 1'b1;
			end else if (loadTx) begin
				txdOut_r <= txByte[0];
			end else if (syncFall & txAct_r) begin
				txdOut_r <= txLine_r[bitCnt_r + BIT_STEP];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			etuCnt_r <= '0;
			halfCnt_r <= 5'h00;
			cardErr_r <= 1'b0;
			rxdOe_r <= 1'b0;
		end else begin
			// frame timer restarts on a new or repeated frame
			if (cardTxGo | cardRxGo | retry) begin
				etuCnt_r <= '0;
				halfCnt_r <= 5'h00;
				cardErr_r <= 1'b0;
			end else begin
				etuCnt_r <= halfTick ? '0 : DIV_W'(etuCnt_r + 1'b1);
				halfCnt_r <= (inCard & halfTick) ? halfCnt_r + 5'h01 : halfCnt_r;
				// Error pulse is sampled at 11 etu, its middle
				if (inCard & halfTick & txAct_r & (halfCnt_r == HC_ERR_START)) begin
					cardErr_r <= !rxdS;
				end
			end
			rxdOe_r <= lineLow;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rxFullIrq_r <= 1'b0;
			rxErrorIrq_r <= 1'b0;
			txEmptyIrq_r <= 1'b0;
		end else begin
			rxFullIrq_r <= stat_nxt.rxFull & ctrl.rxIrqEn;
			rxErrorIrq_r <= (stat_nxt.overrun | stat_nxt.framing | stat_nxt.parity
				| stat_nxt.errSig) & ctrl.rxIrqEn;
			txEmptyIrq_r <= stat_nxt.txEmpty & ctrl.txEn & ctrl.txIrqEn;
		end
	end

	assign status = stat_r;
	assign rxData = rxData_r;
	assign rxFullIrq = rxFullIrq_r;
	assign rxErrorIrq = rxErrorIrq_r;
	assign txEmptyIrq = txEmptyIrq_r;
	assign sckOut = sckOut_r;
	assign sckOe = sckOe_r;
	assign rxdOut = 1'b0;
	assign rxdOe = rxdOe_r;
	assign txdOut = txdOut_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence sqRetry;
		cardDone && txAct_r && cardErr_r;
	endsequence
	sequence sqRestart;
		inCard && halfCnt_r == 5'h00 && $stable(txLine_r);
	endsequence
	chk_overrun_keep: assert property (rxDeliver && stat_r.rxFull |=>
		stat_r.overrun && stat_r.rxFull && $stable(rxData_r))
		else $error("overrun did not keep data");
	chk_rx_load: assert property (setF.rxFull |=>
		stat_r.rxFull && rxData_r == $past(rxByte))
		else $error("received byte not loaded");
	chk_err_block: assert property ($rose(inSync) |->
		!$past(errAny)) else $error("transfer began with error flag");
	chk_idle_high: assert property (inIdle && !ctrl.cardMode ##1 inIdle |->
		sckOut_r) else $error("sync clock not high while idle");
	chk_dtc_clear: assert property (dtcRxRead && !setF.rxFull |=>
		!stat_r.rxFull) else $error("controller read left full flag");
	chk_err_pulse: assert property (inCard && !txAct_r && parErr
		&& halfCnt_r == HC_ERR_START && !cardDone |=> rxdOe_r)
		else $error("no error pulse on parity error");
	chk_guard_quiet: assert property (inCard && txAct_r
		&& halfCnt_r > HC_LAST_SMP + 5'h1 |=> !rxdOe_r)
		else $error("line driven inside guard time");
	chk_retry_frame: assert property (sqRetry |=> sqRestart)
		else $error("character not resent after error");
	chk_card_clock: assert property (ctrl.cardMode [*2] |-> sckOe_r)
		else $error("card clock not driven");
	chk_parity_gen: assert property (loadTx |=>
		txLine_r[9] == ((^txLine_r[8:1]) ^ ctrl.parityOdd))
		else $error("parity bit wrong");
endmodule : serial_sync_card
`default_nettype wire

// ### dv/sync_card_peer.sv
`timescale 1ns/10ps
`default_nettype none
module sync_card_peer
	import serial_card_pkg::*;
(
	// Design pins
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic txdOut,
	input wire logic rxdOe,
	input wire logic cardMode,
	// Driven towards the design
	output logic sckIn,
	output logic rxdIn
);
	logic [7:0] sendB = 8'h00;
	logic [7:0] gotB = 8'h00;
	logic [2:0] idx = 3'h0;
	logic rose = 1'b0;
	logic cardDrv = 1'b0;
	logic cardBit = 1'b1;
	wire logic sck = sckOe ? sckOut : sckIn;
	// pull-up keeps the shared line high unless someone pulls it low
	wire logic cardLine = rxdOe ? 1'b0 : (cardDrv ? cardBit : 1'b1);
	assign rxdIn = cardMode ? cardLine : sendB[idx];
	initial sckIn = 1'b1;
	// a bit stays on the line until a rising edge has taken it
	always @(posedge sck) begin
		gotB[idx] <= txdOut;
		rose <= 1'b1;
	end
	always @(negedge sck) begin
		if (rose && idx != 3'h7) idx <= idx + 3'h1;
	end
	task automatic arm(input logic [7:0] b);
		sendB = b;
		idx = 3'h0;
		rose = 1'b0;
	endtask : arm
	// Link clock stands high between frames
	task automatic ext_frame();
		#3;
		repeat (8) begin
			sckIn = 1'b0;
			#40;
			sckIn = 1'b1;
			#40;
		end
	endtask : ext_frame
	// f[0] start, f[8:1] line data, f[9] parity
	task automatic send_card(input logic [9:0] f);
		cardDrv = 1'b1;
		for (int k = 0; k < 10; k++) begin
			cardBit = f[k];
			#(ETU_NS);
		end
		cardDrv = 1'b0;
	endtask : send_card
endmodule : sync_card_peer
`default_nettype wire

// ### dv/tb_serial_sync_card.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_sync_card
	import serial_card_pkg::*;
;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	ctrl_t ctrl = '0;
	logic txWrite = 1'b0;
	logic [7:0] txData = 8'h00;
	logic dtcTxWrite = 1'b0;
	logic dtcRxRead = 1'b0;
	stat_t clearFlags = '0;
	stat_t status;
	logic [7:0] rxData;
	logic rxFullIrq, rxErrorIrq, txEmptyIrq;
	logic sckIn, sckOut, sckOe, rxdIn, rxdOut, rxdOe, txdOut;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int nFall = 0;
	int nLow = 0;
	int f0;
	logic prevSck = 1'b1;
	logic [31:0] seed = 32'h10E5;
	logic [7:0] b0, b1, held;
	serial_sync_card u_dut (.clk_sys(clk_sys), .nrst(nrst), .ctrl(ctrl), .txWrite(txWrite),
		.txData(txData), .dtcTxWrite(dtcTxWrite), .dtcRxRead(dtcRxRead),
		.clearFlags(clearFlags), .status(status), .rxData(rxData), .rxFullIrq(rxFullIrq),
		.rxErrorIrq(rxErrorIrq), .txEmptyIrq(txEmptyIrq), .sckIn(sckIn), .sckOut(sckOut),
		.sckOe(sckOe), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut));
	sync_card_peer u_peer (.sckOut(sckOut), .sckOe(sckOe), .txdOut(txdOut), .rxdOe(rxdOe),
		.cardMode(ctrl.cardMode), .sckIn(sckIn), .rxdIn(rxdIn));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// Counts clock pin falls; also cuts a hang short
	always @(posedge clk_sys) begin
		prevSck <= sckOut;
		if (prevSck === 1'b1 && sckOut === 1'b0) nFall <= nFall + 1;
		if (rxdOe === 1'b1) nLow <= nLow + 1;
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			n_mismatch = n_mismatch + 1;
			finish_test();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] line_to_data(input logic [7:0] l, input logic m, input logic v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = m ? l[7 - i] : l[i];
		return v ? ~r : r;
	endfunction : line_to_data
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic strobe(input logic tx, input logic rd, input stat_t clr, input logic [7:0] d);
		@(posedge clk_sys);
		dtcTxWrite <= tx;
		dtcRxRead <= rd;
		clearFlags <= clr;
		txData <= d;
		@(posedge clk_sys);
		dtcTxWrite <= 1'b0;
		dtcRxRead <= 1'b0;
		clearFlags <= '0;
		#1;
	endtask : strobe
	task automatic wait_stat(input int i, input int lim);
		int n;
		n = 0;
		while (status[i] !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("status wait", {7'h00, status[i]}, 8'h01);
	endtask : wait_stat
	task automatic finish_test();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		// Full duplex on the internal clock, all interrupts on
		// both enables in one write
		ctrl <= 9'h1E8;
		b0 = rnd();
		b1 = rnd();
		u_peer.arm(b0);
		f0 = nFall;
		strobe(1'b1, 1'b0, '0, b1);
		check("txEmpty", {7'h00, status.txEmpty}, 8'h00);
		check("txEmptyIrq low", {7'h00, txEmptyIrq}, 8'h00);
		wait_stat(2, 400);
		repeat (2) @(posedge clk_sys);
		#1;
		check("rxData", rxData, b0);
		check("rxFullIrq", {7'h00, rxFullIrq}, 8'h01);
		check("peer byte", u_peer.gotB, b1);
		check("pulses", 8'(nFall - f0), 8'h08);
		check("sck idle", {7'h00, sckOut}, 8'h01);
		check("txEmptyIrq", {7'h00, txEmptyIrq}, 8'h01);
		check("txEnd", {7'h00, status.txEnd}, 8'h01);
		// Second character while the first is unread
		held = b0;
		b0 = rnd();
		u_peer.arm(b0);
		strobe(1'b1, 1'b0, '0, rnd());
		wait_stat(5, 400);
		repeat (2) @(posedge clk_sys);
		#1;
		check("rxData kept", rxData, held);
		check("rxFull kept", {7'h00, status.rxFull}, 8'h01);
		check("rxErrorIrq", {7'h00, rxErrorIrq}, 8'h01);
		// Pending transmit must wait for the overrun clear
		b0 = rnd();
		u_peer.arm(b0);
		f0 = nFall;
		strobe(1'b1, 1'b0, '0, rnd());
		repeat (60) @(posedge clk_sys);
		check("held off", 8'(nFall - f0), 8'h00);
		strobe(1'b0, 1'b1, '0, 8'h00);
		check("rxFull read", {7'h00, status.rxFull}, 8'h00);
		strobe(1'b0, 1'b0, 7'h20, 8'h00);
		wait_stat(2, 400);
		check("rxData resumed", rxData, b0);
		// Receive only on the external link clock, random order and levels
		for (int k = 0; k < 3; k++) begin
			strobe(1'b0, 1'b1, '0, 8'h00);
			b0 = rnd();
			@(posedge clk_sys);
			ctrl <= {4'h6, 2'b00, b0[1], b0[2], 1'b0};
			u_peer.arm(b0);
			repeat (4) @(posedge clk_sys);
			u_peer.ext_frame();
			wait_stat(2, 100);
			check("ext rxData", rxData, line_to_data(b0, b0[1], b0[2]));
		end
		// Card mode, inverse convention start character
		strobe(1'b0, 1'b1, '0, 8'h00);
		// enables dropped before the mode changes
		@(posedge clk_sys);
		ctrl <= '0;
		repeat (2) @(posedge clk_sys);
		ctrl <= 9'h0DF;
		f0 = nFall;
		repeat (10) @(posedge clk_sys);
		#1;
		check("card clock oe", {7'h00, sckOe}, 8'h01);
		u_peer.send_card({1'b1, 8'h03, 1'b0});
		wait_stat(2, 8000);
		check("start char", rxData, START_INVERSE);
		check("parity ok", {7'h00, status.parity}, 8'h00);
		check("card pulses", {7'h00, nFall > f0}, 8'h01);
		check("card txdOut", {7'h00, txdOut}, 8'h01);
		// Bad parity: one etu error pulse, no data loaded
		strobe(1'b0, 1'b1, '0, 8'h00);
		f0 = nLow;
		u_peer.send_card({1'b0, 8'h03, 1'b0});
		wait_stat(3, 8000);
		check("err pulse", {7'h00, (nLow - f0) == ETU_NS / 10}, 8'h01);
		check("rxdOut", {7'h00, rxdOut}, 8'h00);
		check("bad not loaded", {7'h00, status.rxFull}, 8'h00);
		check("rxData after bad", rxData, START_INVERSE);
		check("parity irq", {7'h00, rxErrorIrq}, 8'h01);
		finish_test();
	end
endmodule : tb_serial_sync_card
`default_nettype wire
